// [src/bor_arbiter.sv]
// arbiter end: grants the bus to the device or one alternate master
// assumes bus_occupied_n resolved from both ends' enables
module bor_arbiter
  import bor_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_b_in,
  // link
  bor_link_if.arbiter link,
  // alternate master side
  input  wire logic alt_request_in,
  input  wire logic lock_keep_in,
  output logic      alt_grant_out,
  output logic      dev_grant_out
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic hold_s1;
    logic hold_s2;
    logic alt_s1;
    logic alt_s2;
    logic dev_grant;
  } bor_arb_type;

  bor_arb_type st_reg;
  bor_arb_type st_next;

  // ****************************************
  // grant decision
  // ****************************************
  always_comb begin
    st_next         = st_reg;
    st_next.req_s1  = link.ownership_request_n;
    st_next.req_s2  = st_reg.req_s1;
    st_next.hold_s1 = link.atomic_hold_n;
    st_next.hold_s2 = st_reg.hold_s1;
    st_next.alt_s1  = alt_request_in;
    st_next.alt_s2  = st_reg.alt_s1;
    // single grant at a time; device default owner   see RULE1
    if (st_reg.req_s2 == BOR_ASSERT) begin
      st_next.dev_grant = 1'b1;
    end else if (st_reg.alt_s2) begin
      // locked sequence keeps its grant   see RULE11
      st_next.dev_grant = lock_keep_in &&
                          st_reg.hold_s2 == BOR_ASSERT &&
                          st_reg.dev_grant;
    end else begin
      st_next.dev_grant = 1'b1;  // parked   see RULE21
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      st_reg <= '{default: 1'b1, alt_s1: 1'b0, alt_s2: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.ownership_grant_n = ~st_reg.dev_grant;
  assign dev_grant_out          = st_reg.dev_grant;
  assign alt_grant_out          = ~st_reg.dev_grant;
endmodule // bor_arbiter

// [src/bor_link_if.sv]
// interface joining the device end and the arbiter end
// assumes the bench resolves shared wires from the enables
interface bor_link_if;
  logic ownership_request_n;
  logic ownership_grant_n;
  logic bus_occupied_n_o;
  logic bus_occupied_n_oe;
  logic bus_occupied_n;      // resolved level, driven by bench
  logic transfer_active_n_o;
  logic transfer_active_n_oe;
  logic transfer_start_n;
  logic addr_oe;
  logic [31:0] addr;
  logic atomic_hold_n;
  logic atomic_final_n;
  logic transfer_ack_n;
  logic transfer_error_n;

  modport device (
    output ownership_request_n, bus_occupied_n_o, bus_occupied_n_oe,
    output transfer_active_n_o, transfer_active_n_oe, transfer_start_n,
    output addr_oe, addr, atomic_hold_n, atomic_final_n,
    input  ownership_grant_n, bus_occupied_n, transfer_ack_n,
    input  transfer_error_n
  );
  modport arbiter (
    input  ownership_request_n, bus_occupied_n, atomic_hold_n,
    input  atomic_final_n,
    output ownership_grant_n
  );
endinterface : bor_link_if

// [src/bor_pkg.sv]
// package for the bus ownership requester and its arbiter-side partner
// assumes one bus clock shared by both ends
package bor_pkg;
  // ****************************************
  // widths and levels
  // ****************************************
  localparam int          BOR_ADDR_W   = 32;
  localparam int          BOR_LINE_N   = 4;
  localparam logic        BOR_ASSERT   = 1'h0;
  localparam logic        BOR_NEGATE   = 1'h1;
  localparam logic [31:0] BOR_ADDR_ANY = 32'h0000_0000;
  localparam logic [1:0]  BOR_BEAT_ONE = 2'h1;

  // ****************************************
  // device ownership states
  // ****************************************
  typedef enum logic [2:0] {
    BOR_IDLE,      // bus not owned, sampling occupancy
    BOR_IMPLICIT,  // granted idle bus, nothing to do
    BOR_CYCLE,     // explicit owner, transfer in flight
    BOR_HOLD,      // explicit owner between cycles
    BOR_RELEASE    // driving inactive levels before letting go
  } bor_state_type;
endpackage : bor_pkg

// [src/bor_requester.sv]
// device end: requests, takes, holds and gives up the shared bus
// assumes an external arbiter on the link and one bus clock
// Functional notes
// RULE1 - one owner; external arbiter decides grants
// RULE2 - everything changes on rising clock edges
// RULE3 - one dead clock between successive owners
// RULE4 - request while pending until cycle starts
// RULE5 - after start keep request only if more
// RULE6 - granted already: request with transfer start
// RULE7 - request is always actively driven
// RULE8 - grant lost mid-cycle: finish then release
// RULE9 - four-beat inhibited line is one cycle
// RULE10 - locked read and write may be split
// RULE11 - arbiter may hold grant during lock
// RULE12 - mark final write of locked sequence
// RULE13 - wait for occupancy negated, then take bus
// RULE14 - hold occupancy while granted; release on loss
// RULE15 - drive inactive before tri-stating outputs
// RULE16 - other master negates before tri-stating
// RULE17 - retry with grant lost: release, re-request
// RULE18 - granted idle bus: implicit ownership
// RULE19 - implicit owner releases on occupancy or loss
// RULE20 - request during implicit: start all at once
// RULE21 - single-master system may tie grant on
// RULE22 - ack plus error with no grant: retry
// RULE23 - tri-state outputs are value plus enable
module bor_requester
  import bor_pkg::*;
#(
  parameter int LINE_N = BOR_LINE_N
)
(
  // clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_b_in,
  // internal access request
  input  wire logic                  access_valid_in,
  input  wire logic [BOR_ADDR_W-1:0] access_addr_in,
  input  wire logic                  access_line_in,
  input  wire logic                  access_locked_in,
  input  wire logic                  access_lock_last_in,
  input  wire logic                  access_more_in,
  // access status
  output logic                       access_taken_out,
  output logic                       access_done_out,
  output logic                       owner_out,
  // link
  bor_link_if.device                 link
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    bor_state_type         state;
    logic                  grant_s1;
    logic                  grant_s2;
    logic                  occ_s1;
    logic                  occ_s2;
    logic                  ack_s1;
    logic                  ack_s2;
    logic                  err_s1;
    logic                  err_s2;
    logic [1:0]            beats;
    logic                  line;
    logic                  lock_last;
    logic                  more;
    logic                  retry_pend;
    logic                  req_n;
    logic                  occ_n;
    logic                  occ_oe;
    logic                  act_n;
    logic                  act_oe;
    logic                  start_n;
    logic                  addr_oe;
    logic [BOR_ADDR_W-1:0] addr;
    logic                  hold_n;
    logic                  final_n;
    logic                  taken;
    logic                  done;
  } bor_dev_type;

  bor_dev_type st_reg;
  bor_dev_type st_next;

  logic granted;
  logic bus_idle;
  logic want;
  logic ended;
  logic retry;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next          = st_reg;
    // pins pass two flops before use   see RULE2
    st_next.grant_s1 = link.ownership_grant_n;
    st_next.grant_s2 = st_reg.grant_s1;
    st_next.occ_s1   = link.bus_occupied_n;
    st_next.occ_s2   = st_reg.occ_s1;
    st_next.ack_s1   = link.transfer_ack_n;
    st_next.ack_s2   = st_reg.ack_s1;
    st_next.err_s1   = link.transfer_error_n;
    st_next.err_s2   = st_reg.err_s1;
    granted  = st_reg.grant_s2 == BOR_ASSERT;
    bus_idle = st_reg.occ_s2 == BOR_NEGATE;  // see RULE16
    // valid still stands in the cycle after taken
    want     = (access_valid_in && !st_reg.taken) || st_reg.retry_pend;
    ended    = st_reg.ack_s2 == BOR_ASSERT;
    retry    = ended && st_reg.err_s2 == BOR_ASSERT;
    st_next.taken   = 1'b0;
    st_next.done    = 1'b0;
    st_next.start_n = BOR_NEGATE;
    // request follows pending work, always driven   see RULE4 RULE7
    st_next.req_n   = want ? BOR_ASSERT : BOR_NEGATE;

    unique case (st_reg.state)
      BOR_IDLE: begin
        if (granted && bus_idle) begin
          if (want) begin
            // prior owner gone; take bus and start   see RULE13 RULE3
            st_next.state = BOR_CYCLE;
          end else begin
            // idle bus parked here   see RULE18
            st_next.state   = BOR_IMPLICIT;
            st_next.addr_oe = 1'b1;
            st_next.addr    = BOR_ADDR_ANY;
          end
        end
      end
      BOR_IMPLICIT: begin
        if (!granted || !bus_idle) begin
          st_next.state   = BOR_IDLE;  // see RULE19
          st_next.addr_oe = 1'b0;
        end else if (want) begin
          st_next.state = BOR_CYCLE;   // see RULE20
        end
      end
      BOR_CYCLE: begin
        // keep asking only while more work waits   see RULE5
        st_next.req_n = (want || st_reg.more) ? BOR_ASSERT : BOR_NEGATE;
        if (retry && !granted) begin
          // give up; the access stays pending   see RULE17
          st_next.state      = BOR_RELEASE;
          st_next.retry_pend = 1'b1;
          st_next.req_n      = BOR_ASSERT;
          st_next.occ_n      = BOR_NEGATE;
          st_next.act_n      = BOR_NEGATE;
          st_next.final_n    = BOR_NEGATE;
        end else if (retry) begin
          // same access again from hold
          st_next.state      = BOR_HOLD;
          st_next.retry_pend = 1'b1;
          st_next.req_n      = BOR_ASSERT;
          st_next.act_n      = BOR_NEGATE;
        end else if (ended && st_reg.line &&
                     st_reg.beats != 2'(LINE_N - 1)) begin
          // line beats stay together despite grant   see RULE9
          st_next.beats = st_reg.beats + BOR_BEAT_ONE;
        end else if (ended) begin
          st_next.done       = 1'b1;
          st_next.retry_pend = 1'b0;
          st_next.act_n      = BOR_NEGATE;
          st_next.final_n    = BOR_NEGATE;
          // lock hint stays up until the final write ends
          if (st_reg.lock_last) begin
            st_next.hold_n = BOR_NEGATE;
          end
          // finish first, then yield if grant gone   see RULE8 RULE10
          if (!granted) begin
            st_next.state = BOR_RELEASE;
            st_next.occ_n = BOR_NEGATE;  // see RULE14 RULE15
          end else begin
            st_next.state = BOR_HOLD;
          end
        end
      end
      BOR_HOLD: begin
        if (!granted) begin
          st_next.state = BOR_RELEASE;
          st_next.occ_n = BOR_NEGATE;    // see RULE14 RULE15
        end else if (want) begin
          st_next.state = BOR_CYCLE;     // see RULE5
        end
      end
      BOR_RELEASE: begin
        // enables drop one clock after inactive drive   see RULE23
        st_next.state   = BOR_IDLE;
        st_next.occ_oe  = 1'b0;
        st_next.act_oe  = 1'b0;
        st_next.addr_oe = 1'b0;
      end
    endcase

    // common entry to a bus cycle   see RULE6 RULE20
    if (st_next.state == BOR_CYCLE && st_reg.state != BOR_CYCLE) begin
      st_next.start_n   = BOR_ASSERT;
      st_next.req_n     = BOR_ASSERT;  // see RULE6
      st_next.occ_n     = BOR_ASSERT;
      st_next.occ_oe    = 1'b1;
      st_next.act_n     = BOR_ASSERT;
      st_next.act_oe    = 1'b1;
      st_next.addr_oe   = 1'b1;
      st_next.beats     = '0;
      // a retried access keeps its own address and attributes
      if (!st_reg.retry_pend) begin
        st_next.addr      = access_addr_in;
        st_next.line      = access_line_in;
        st_next.lock_last = access_lock_last_in;
        st_next.more      = access_more_in;
        st_next.taken     = 1'b1;
        st_next.hold_n    = access_locked_in ? BOR_ASSERT : BOR_NEGATE;
      end
      // final write of a locked sequence, kept on retry   see RULE12
      st_next.final_n   = st_next.lock_last ? BOR_ASSERT : BOR_NEGATE;
      st_next.retry_pend = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk_in) begin  // see RULE2
    if (!rst_b_in) begin
      st_reg         <= '0;
      st_reg.state   <= BOR_IDLE;
      st_reg.grant_s1 <= BOR_NEGATE;
      st_reg.grant_s2 <= BOR_NEGATE;
      st_reg.occ_s1  <= BOR_NEGATE;
      st_reg.occ_s2  <= BOR_NEGATE;
      st_reg.ack_s1  <= BOR_NEGATE;
      st_reg.ack_s2  <= BOR_NEGATE;
      st_reg.err_s1  <= BOR_NEGATE;
      st_reg.err_s2  <= BOR_NEGATE;
      st_reg.req_n   <= BOR_NEGATE;
      st_reg.occ_n   <= BOR_NEGATE;
      st_reg.act_n   <= BOR_NEGATE;
      st_reg.start_n <= BOR_NEGATE;
      st_reg.hold_n  <= BOR_NEGATE;
      st_reg.final_n <= BOR_NEGATE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs, all from flops
  // ****************************************
  assign link.ownership_request_n  = st_reg.req_n;
  assign link.bus_occupied_n_o     = st_reg.occ_n;
  assign link.bus_occupied_n_oe    = st_reg.occ_oe;
  assign link.transfer_active_n_o  = st_reg.act_n;
  assign link.transfer_active_n_oe = st_reg.act_oe;
  assign link.transfer_start_n     = st_reg.start_n;
  assign link.addr_oe              = st_reg.addr_oe;
  assign link.addr                 = st_reg.addr;
  assign link.atomic_hold_n        = st_reg.hold_n;
  assign link.atomic_final_n       = st_reg.final_n;
  assign access_taken_out          = st_reg.taken;
  assign access_done_out           = st_reg.done;
  assign owner_out                 = st_reg.occ_oe;
endmodule // bor_requester

// [verification/bor_assertions.sv]
// checker for the ownership link between the device and arbiter ends
// assumes plain link signals, one bus clock, sync active-low reset
module bor_assertions
  import bor_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // link
  input wire logic ownership_request_n,
  input wire logic bus_occupied_n_o,
  input wire logic bus_occupied_n_oe,
  input wire logic bus_occupied_n,
  input wire logic transfer_active_n_o,
  input wire logic transfer_active_n_oe,
  input wire logic transfer_start_n,
  input wire logic addr_oe,
  input wire logic atomic_final_n,
  input wire logic transfer_ack_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***************
  // link properties
  // ***************
  default clocking dc @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  chk_start_owns: assert property (
    !transfer_start_n |-> bus_occupied_n_oe && !bus_occupied_n_o
      && transfer_active_n_oe && !transfer_active_n_o)
    else $error("start without taking the bus");
  chk_start_request: assert property (
    !transfer_start_n |-> !ownership_request_n)
    else $error("start without request");
  chk_start_pulse: assert property (
    !transfer_start_n |=> transfer_start_n)
    else $error("start longer than one cycle");
  chk_occ_release: assert property (
    $fell(bus_occupied_n_oe) |-> $past(bus_occupied_n_o))
    else $error("occupied released while low");
  chk_act_release: assert property (
    $fell(transfer_active_n_oe) |-> $past(transfer_active_n_o))
    else $error("active released while low");
  chk_wait_idle: assert property (
    $rose(bus_occupied_n_oe) |-> $past(bus_occupied_n)
      && $past(bus_occupied_n, 2))
    else $error("bus taken while occupied");
  // ack reaches the state two edges late, so four quiet samples
  chk_cycle_holds: assert property (
    transfer_active_n_oe && !transfer_active_n_o && transfer_ack_n
      && $past(transfer_ack_n) && $past(transfer_ack_n, 2)
      && $past(transfer_ack_n, 3) |=> !transfer_active_n_o)
    else $error("cycle ended without ack");
  chk_implicit_quiet: assert property (
    addr_oe && !bus_occupied_n_oe |-> transfer_start_n
      && !transfer_active_n_oe)
    else $error("implicit owner drives transfer");
  chk_final_start: assert property (
    $fell(atomic_final_n) |-> !transfer_start_n)
    else $error("final mark outside cycle start");
endmodule // bor_assertions

// [verification/bus_ownership_requester_test.sv]
// bench joining the device end and arbiter end through the link
// assumes the bench plays pull-up, alternate master and slave acks
module bus_ownership_requester_test
  import bor_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_in;
  logic        rst_b_in;
  logic        vld, ln, lk, la, mo, alt_rq, keep, alt_gnt, done;
  logic        ack_n, err_n, alt_drv, alt_val, tkn, own;
  logic [31:0] adr;
  int          err_total, compares, done_cnt;

  bor_link_if link ();
  // pull-up unless one of the masters drives
  assign link.bus_occupied_n = link.bus_occupied_n_oe ?
    link.bus_occupied_n_o : alt_drv ? alt_val : 1'h1;
  assign link.transfer_ack_n = ack_n;
  assign link.transfer_error_n = err_n;

  bor_requester u_bor_requester (
    .sys_clk_in,
    .rst_b_in,
    .access_valid_in     (vld),
    .access_addr_in      (adr),
    .access_line_in      (ln),
    .access_locked_in    (lk),
    .access_lock_last_in (la),
    .access_more_in      (mo),
    .access_taken_out    (tkn),
    .access_done_out     (done),
    .owner_out           (own),
    .link
  );
  bor_arbiter u_bor_arbiter (
    .sys_clk_in,
    .rst_b_in,
    .link,
    .alt_request_in (alt_rq),
    .lock_keep_in   (keep),
    .alt_grant_out  (alt_gnt),
    .dev_grant_out  ()
  );
  bor_assertions u_bor_assertions (
    .sys_clk_in,
    .rst_b_in,
    .ownership_request_n (link.ownership_request_n),
    .bus_occupied_n_o    (link.bus_occupied_n_o),
    .bus_occupied_n_oe   (link.bus_occupied_n_oe),
    .bus_occupied_n      (link.bus_occupied_n),
    .transfer_active_n_o (link.transfer_active_n_o),
    .transfer_active_n_oe(link.transfer_active_n_oe),
    .transfer_start_n    (link.transfer_start_n),
    .addr_oe             (link.addr_oe),
    .atomic_final_n      (link.atomic_final_n),
    .transfer_ack_n      (link.transfer_ack_n)
  );

  initial begin
    sys_clk_in = 1'h0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // **************************************
  // alternate master and shared-wire watch
  // **************************************
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      alt_drv <= 1'h0;
      alt_val <= 1'h1;
    end else if (alt_gnt && alt_rq && !link.bus_occupied_n_oe
                 && (alt_drv || link.bus_occupied_n)) begin
      alt_drv <= 1'h1;
      alt_val <= 1'h0;
    end else if (alt_drv && !alt_val) begin
      alt_val <= 1'h1;
    end else begin
      alt_drv <= 1'h0;
    end
  end

  always @(negedge sys_clk_in) begin
    if (done === 1'h1)
      done_cnt++;
    if (link.bus_occupied_n_oe === 1'h1)
      chk(alt_drv, 1'h0);
  end

  // *****
  // tasks
  // *****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic till_start();
    int n;
    for (n = 0; n < 80 && link.transfer_start_n !== BOR_ASSERT; n++)
      @(negedge sys_clk_in);
    chk(n < 80, 1'h1);
  endtask

  task automatic beat(input logic e);
    repeat (4) @(posedge sys_clk_in);
    ack_n <= BOR_ASSERT;
    err_n <= e;
    @(posedge sys_clk_in);
    ack_n <= BOR_NEGATE;
    err_n <= BOR_NEGATE;
  endtask

  // one access; rt ends the first try with relinquish and retry
  task automatic run(input logic [31:0] a, input logic l, m, k, f, rt);
    int n;
    int d0;
    @(posedge sys_clk_in);
    vld <= 1'h1;
    adr <= a;
    ln <= l;
    mo <= m;
    lk <= k;
    la <= f;
    d0 = done_cnt;
    till_start();
    chk(tkn, 1'h1);
    chk(own, 1'h1);
    chk(link.ownership_request_n, BOR_ASSERT);
    chk(link.addr, a);
    chk(link.atomic_final_n, !(k && f));
    @(posedge sys_clk_in);
    vld <= 1'h0;
    if (rt) begin
      beat(BOR_ASSERT);
      repeat (8) @(negedge sys_clk_in);
      chk(link.ownership_request_n, BOR_ASSERT);
      chk(link.bus_occupied_n_oe, 1'h0);
      @(posedge sys_clk_in);
      alt_rq <= 1'h0;
      till_start();
      d0 = done_cnt;
    end else begin
      @(negedge sys_clk_in);
      chk(link.ownership_request_n, !m);
    end
    for (n = 0; n < (l ? BOR_LINE_N : 1); n++) begin
      chk(done_cnt - d0, 0);
      beat(BOR_NEGATE);
    end
    for (n = 0; n < 40 && done_cnt == d0; n++)
      @(negedge sys_clk_in);
    chk(done_cnt - d0, 1);
  endtask

  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge sys_clk_in);
    err_total++;
    tally_and_finish();
  end

  initial begin
    {rst_b_in, vld, ln, lk, la, mo, alt_rq, keep} = 8'h00;
    {ack_n, err_n} = 2'h3;
    adr = 32'h0000_0000;
    repeat (6) @(posedge sys_clk_in);
    rst_b_in <= 1'h1;
    repeat (8) @(negedge sys_clk_in);
    chk(link.addr_oe, 1'h1);
    chk(link.bus_occupied_n_oe, 1'h0);
    chk(link.addr, BOR_ADDR_ANY);
    run(32'h0000_0100, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    @(posedge sys_clk_in);
    alt_rq <= 1'h1;
    repeat (10) @(negedge sys_clk_in);
    chk(link.addr_oe, 1'h0);
    chk(link.bus_occupied_n, BOR_ASSERT);
    run(32'h0000_0200, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    repeat (8) @(negedge sys_clk_in);
    chk(link.bus_occupied_n_oe, 1'h0);
    chk(link.bus_occupied_n, BOR_ASSERT);
    @(posedge sys_clk_in);
    keep <= 1'h1;
    run(32'h0000_0300, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    run(32'h0000_0304, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
    @(posedge sys_clk_in);
    keep <= 1'h0;
    run(32'h0000_0400, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    repeat (4) @(posedge sys_clk_in);
    tally_and_finish();
  end
endmodule // bus_ownership_requester_test
